// *** lp_state_map.vh ***
// Purpose: Constants for the low-power state control of the DRAM device
// Assumes: 250 MHz system clock, 4 ns period
// Notes: Hold and strobe access counts derive from times in picoseconds; the rest are given in cycles
`ifndef LP_STATE_MAP_VH
`define LP_STATE_MAP_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_PS 4000
`define CKE_INPUT_HOLD_TIME_PS 250
`define CKE_INPUT_HOLD_CYC (((`CKE_INPUT_HOLD_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
`define MODE_WRITE_CYCLE_CYC 5
`define POWERDOWN_EXIT_LATENCY_CYC 2
`define READ_LATENCY_CYCLES 8
`define STROBE_ACCESS_DELAY_PS 5500
`define STROBE_ACCESS_CYC ((`STROBE_ACCESS_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BURST_LENGTH 4
`define MODE_READ_CKE_CYC (`READ_LATENCY_CYCLES + `STROBE_ACCESS_CYC + `BURST_LENGTH / 2 + 1)
`define BUSY_CNT_W 6
`define OP_HOLD_CYC 4

// ----------------------------------------
// Command decode on CA0..CA3 with CS low
// ----------------------------------------
`define CMD_MODE_WRITE 4'h0
`define CMD_MODE_READ 4'h8
`define CMD_REF 4'h4
`define CMD_ACT_BIT 2'h2
`define CMD_PRE 4'hB

`endif

// *** busy_timer.v ***
// Purpose: Down counter marking an operation as still in progress
// Assumes: Load and count on one clock
// Notes: Busy while count is nonzero
`timescale 1ns/10ps
module busy_timer (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire load_i,
  input wire [5:0] value_i,
  output wire busy_o
);
  reg [5:0] cnt_reg;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 6'h00;
    end else if (load_i) begin
      cnt_reg <= value_i;
    end else if (cnt_reg != 6'h00) begin
      cnt_reg <= cnt_reg - 6'h01;
    end
  end

  assign busy_o = (cnt_reg != 6'h00);
endmodule

// *** dram_low_power_entry_exit.v ***
// Purpose: Low-power state control inside the DRAM device
// Assumes: Command pins are synchronised to sys_clk_i
// Notes: Ordinary and deep power-down, no-operation decode, error flags
// Operation
// - Clock-enable low, select low, CA0 CA1 high, CA2 low enters deep power-down.
// - Activate, precharge, refresh still complete after clock-enable drops.
// - Deep power-down entry makes all stored data undefined.
// - In deep power-down only clock-enable is seen; outputs stay disabled. The first deep cycle still checks select and CA0..CA2 for no-operation.
// - After deep power-down exit, full initialization needed before operation.
// - No-operation is select high, or select low with CA0..CA2 high.
// - No-operation never aborts operations in progress.
// - Illegal command or timing needs full reinitialization to recover.
// - Clock-enable low with select high enters power-down; high exits.
`timescale 1ns/10ps
`include "lp_state_map.vh"
module dram_low_power_entry_exit (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire cke_i,
  input wire cs_b_i,
  input wire [3:0] ca_i,
  input wire init_done_i,
  output reg powerdown_o,
  output reg deep_powerdown_o,
  output reg data_valid_o,
  output reg outputs_en_o,
  output reg op_busy_o,
  output reg need_init_o,
  output reg nop_o,
  output reg error_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg cke_s1_reg, cke_reg, cs_s1_reg, cs_b_reg;
  reg [3:0] ca_s1_reg, ca_reg;
  reg cke_prev_reg;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cke_s1_reg <= 1'b0;
      cke_reg <= 1'b0;
      cke_prev_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_b_reg <= 1'b1;
      ca_s1_reg <= 4'hF;
      ca_reg <= 4'hF;
    end else begin
      cke_s1_reg <= cke_i;
      cke_reg <= cke_s1_reg;
      cke_prev_reg <= cke_reg;
      cs_s1_reg <= cs_b_i;
      cs_b_reg <= cs_s1_reg;
      ca_s1_reg <= ca_i;
      ca_reg <= ca_s1_reg;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  localparam ST_IDLE = 4'h1;
  localparam ST_PD = 4'h2;
  localparam ST_DEEP = 4'h4;
  localparam ST_INIT = 4'h8;

  reg [3:0] state_reg, state_next;
  reg deep_first_reg;
  wire active_st = (state_reg == ST_IDLE);
  wire sel = active_st && cke_prev_reg && cke_reg && !cs_b_reg;
  wire is_nop = cs_b_reg || (ca_reg[2:0] == 3'h7);
  wire cmd_mode_read = sel && (ca_reg == `CMD_MODE_READ);
  wire cmd_mode_write = sel && (ca_reg == `CMD_MODE_WRITE);
  wire cmd_ref = sel && (ca_reg == `CMD_REF);
  wire cmd_act = sel && (ca_reg[1:0] == `CMD_ACT_BIT);
  wire cmd_pre = sel && (ca_reg == `CMD_PRE);
  wire cke_fall = cke_prev_reg && !cke_reg;
  wire deep_code = !cs_b_reg && (ca_reg[2:0] == 3'h3);
  wire pd_code = cs_b_reg;
  wire nop_steady = (cke_prev_reg == cke_reg) && is_nop;

  // ----------------------------------------
  // Timer spans
  // ----------------------------------------
  // Low at the full mode count is legal, so mode windows end one short
  wire [31:0] mode_read_span = `MODE_READ_CKE_CYC - 1;
  wire [31:0] mode_write_span = `MODE_WRITE_CYCLE_CYC - 1;
  wire [31:0] op_hold_span = `OP_HOLD_CYC;
  wire [31:0] cke_hold_span = `CKE_INPUT_HOLD_CYC;

  // ----------------------------------------
  // Operation timers
  // ----------------------------------------
  wire mr_busy, arr_busy;
  wire mr_load = cmd_mode_read || cmd_mode_write;
  wire [5:0] mr_val = cmd_mode_read ? mode_read_span[5:0] : mode_write_span[5:0];
  busy_timer u_mr_timer (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(mr_load),
    .value_i(mr_val),
    .busy_o(mr_busy)
  );

  // Array operations keep running across clock-enable drop
  wire arr_load = cmd_act || cmd_pre || cmd_ref;
  busy_timer u_arr_timer (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(arr_load),
    .value_i(op_hold_span[5:0]),
    .busy_o(arr_busy)
  );

  wire hold_busy;
  wire hold_load = cmd_act || cmd_pre;
  busy_timer u_hold_timer (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .load_i(hold_load),
    .value_i(cke_hold_span[5:0]),
    .busy_o(hold_busy)
  );

  // ----------------------------------------
  // Illegal events
  // ----------------------------------------
  wire early_drop = active_st && cke_fall && (mr_busy || hold_busy);
  wire bad_after_deep = deep_first_reg && !is_nop;
  wire illegal = early_drop || bad_after_deep;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cke_fall && deep_code) begin
          state_next = ST_DEEP;
        end else if (cke_fall && pd_code) begin
          state_next = ST_PD;
        end
      end
      ST_PD: begin
        if (cke_reg) begin
          state_next = ST_IDLE;
        end
      end
      ST_DEEP: begin
        if (cke_reg) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_done_i) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
      deep_first_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      deep_first_reg <= (state_reg == ST_IDLE) && (state_next == ST_DEEP);
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      powerdown_o <= 1'b0;
      deep_powerdown_o <= 1'b0;
      data_valid_o <= 1'b1;
      outputs_en_o <= 1'b1;
      op_busy_o <= 1'b0;
      need_init_o <= 1'b0;
      nop_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      powerdown_o <= (state_next == ST_PD);
      deep_powerdown_o <= (state_next == ST_DEEP);
      outputs_en_o <= (state_next == ST_IDLE);
      op_busy_o <= mr_busy || arr_busy;
      nop_o <= active_st && nop_steady;
      if (state_next == ST_DEEP) begin
        data_valid_o <= 1'b0;
      end else if (state_reg == ST_INIT && init_done_i) begin
        data_valid_o <= 1'b1;
      end
      need_init_o <= (state_next == ST_INIT);
      if (illegal) begin
        error_o <= 1'b1;
      end else if (state_reg == ST_INIT && init_done_i) begin
        error_o <= 1'b0;
      end
    end
  end
endmodule

// *** lp_props.sv ***
// Purpose: Checker for low-power control
// Assumes: Sees top ports only
// Notes: Pin events show 3 edges later
`timescale 1ns/10ps
module lp_props (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire cke_i,
  input wire cs_b_i,
  input wire [3:0] ca_i,
  input wire init_done_i,
  input wire powerdown_o,
  input wire deep_powerdown_o,
  input wire data_valid_o,
  input wire outputs_en_o,
  input wire op_busy_o,
  input wire need_init_o,
  input wire nop_o,
  input wire error_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_deep_entry: assert property ($rose(deep_powerdown_o) |->
    $past(!cke_i && !cs_b_i && ca_i[2:0] == 3'h3, 3)) else $error("deep cause");
  chk_deep_data: assert property (deep_powerdown_o |-> !data_valid_o)
    else $error("data kept");
  chk_deep_quiet: assert property (deep_powerdown_o |-> !outputs_en_o && !nop_o)
    else $error("deep outputs");
  chk_deep_next_nop: assert property ($rose(deep_powerdown_o) &&
    !$past(cs_b_i || &ca_i[2:0], 2) |-> ##[0:2] error_o) else $error("no flag");
  chk_exit_cause: assert property ($rose(need_init_o) |->
    $past(deep_powerdown_o) && $past(cke_i, 3)) else $error("exit cause");
  chk_init_done: assert property (need_init_o && init_done_i |=>
    !need_init_o && data_valid_o && outputs_en_o) else $error("init");
  chk_pd_entry: assert property ($rose(powerdown_o) |->
    $past(!cke_i && cs_b_i, 3)) else $error("pd entry");
  chk_pd_exit: assert property ($fell(powerdown_o) |-> $past(cke_i, 3))
    else $error("pd exit");
  chk_nop_steady: assert property (nop_o |->
    $past(cke_i, 3) == $past(cke_i, 4) && $past(cs_b_i || &ca_i[2:0], 3))
    else $error("nop");
  chk_err_sticky: assert property (error_o && !init_done_i |=> error_o)
    else $error("error lost");
endmodule
bind dram_low_power_entry_exit lp_props chk_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .cke_i(cke_i), .cs_b_i(cs_b_i), .ca_i(ca_i), .init_done_i(init_done_i),
  .powerdown_o(powerdown_o), .deep_powerdown_o(deep_powerdown_o),
  .data_valid_o(data_valid_o), .outputs_en_o(outputs_en_o), .op_busy_o(op_busy_o),
  .need_init_o(need_init_o), .nop_o(nop_o), .error_o(error_o));

// *** ctrl_model.sv ***
// Purpose: Memory controller model
// Assumes: Pins change at falling edge
// Notes: Clock never stopped
`timescale 1ns/10ps
module ctrl_model (
  input wire sys_clk_i,
  output logic cke_o,
  output logic cs_b_o,
  output logic [3:0] ca_o
);
  // ----------------------------------------
  // Pin driver
  // ----------------------------------------
  initial begin
    cke_o = 1'b1;
    cs_b_o = 1'b1;
    ca_o = 4'hF;
  end
  // Holds pins n cycles; idle is select high
  task send(input logic k, input logic s, input logic [3:0] c, input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      cke_o = k;
      cs_b_o = s;
      ca_o = c;
    end
  endtask
endmodule

// *** testbench.sv ***
// Purpose: Bench for low-power control
// Assumes: Model drives pins
// Notes: Waits cover sync latency
`timescale 1ns/10ps
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic sys_clk_i;
  logic rst_b_i;
  logic init_done_i;
  int bad_count;
  int samples_checked;
  wire cke_w, cs_b_w;
  wire [3:0] ca_w;
  wire powerdown_o, deep_powerdown_o, data_valid_o, outputs_en_o;
  wire op_busy_o, need_init_o, nop_o, error_o;
  ctrl_model ctl_u (.sys_clk_i(sys_clk_i), .cke_o(cke_w), .cs_b_o(cs_b_w), .ca_o(ca_w));
  dram_low_power_entry_exit dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .cke_i(cke_w), .cs_b_i(cs_b_w), .ca_i(ca_w), .init_done_i(init_done_i),
    .powerdown_o(powerdown_o), .deep_powerdown_o(deep_powerdown_o),
    .data_valid_o(data_valid_o), .outputs_en_o(outputs_en_o), .op_busy_o(op_busy_o),
    .need_init_o(need_init_o), .nop_o(nop_o), .error_o(error_o));
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_cmd_pd(input logic [3:0] code, input int gap, input logic exp, input logic busy);
    ctl_u.send(1'b1, 1'b0, code, 1);
    ctl_u.send(1'b1, 1'b1, 4'hF, gap - 1);
    ctl_u.send(1'b0, 1'b1, 4'hF, 5);
    `CMP(op_busy_o, busy)
    `CMP(error_o, exp)
    if (!exp) `CMP(powerdown_o, 1'b1)
    ctl_u.send(1'b1, 1'b1, 4'hF, 6);
    `CMP(powerdown_o, 1'b0)
  endtask
  task t_deep(input logic bad);
    ctl_u.send(1'b0, 1'b0, 4'h3, 1);
    ctl_u.send(1'b0, !bad, 4'h0, 1);
    ctl_u.send(1'b0, 1'b0, 4'h8, 4);
    `CMP({deep_powerdown_o, outputs_en_o, data_valid_o}, 3'h4)
    `CMP(nop_o, 1'b0)
    `CMP(error_o, bad)
    ctl_u.send(1'b1, 1'b1, 4'hF, 5);
    `CMP({need_init_o, data_valid_o, deep_powerdown_o}, 3'h4)
    init_done_i = 1'b1;
    ctl_u.send(1'b1, 1'b1, 4'hF, 2);
    `CMP({need_init_o, data_valid_o, outputs_en_o, error_o}, 4'h6)
    init_done_i = 1'b0;
    ctl_u.send(1'b1, 1'b1, 4'hF, 3);
  endtask
  task conclude;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i; // Fixed rate, never stopped
  end
  initial begin
    rst_b_i = 1'b0;
    init_done_i = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    ctl_u.send(1'b1, 1'b1, 4'hF, 4);
    `CMP({powerdown_o, deep_powerdown_o, need_init_o, error_o}, 4'h0)
    `CMP({data_valid_o, outputs_en_o}, 2'h3)
    `CMP(nop_o, 1'b1)
    t_cmd_pd(4'h2, 2, 1'b0, 1'b1);
    t_cmd_pd(4'hB, 2, 1'b0, 1'b1);
    t_cmd_pd(4'h0, 6, 1'b0, 1'b0);
    t_deep(1'b0);
    t_deep(1'b1);
    t_cmd_pd(4'h8, 2, 1'b1, 1'b1);
    conclude;
  end
  initial begin
    #4000;
    bad_count++;
    conclude;
  end
endmodule
